// *** shared/hwmon_regs.svh ***
// Offsets, field positions, reset values and rates of the monitor front end
`ifndef HWMON_REGS_SVH
`define HWMON_REGS_SVH

// I/O port offsets from the base address
`define HWM_PORT_INDEX 16'h0005
`define HWM_PORT_DATA 16'h0006

// Bank numbers
`define HWM_BANK0 3'h0
`define HWM_BANK1 3'h1
`define HWM_BANK2 3'h2
`define HWM_BANK4 3'h4
`define HWM_BANK6 3'h6

// Register indices
`define HWM_IDX_FANFREQ 7'h00
`define HWM_IDX_FANMODE 7'h04
`define HWM_IDX_OVTCFG 7'h18
`define HWM_IDX_SENS4 7'h28
`define HWM_IDX_SENS5 7'h29
`define HWM_IDX_SENS6 7'h2a
`define HWM_IDX_STAT_A 7'h41
`define HWM_IDX_STAT_B 7'h42
`define HWM_IDX_BANKSEL 7'h4e
`define HWM_IDX_SENS_EN 7'h52
`define HWM_IDX_PWR_VAL 7'h67
`define HWM_IDX_PWR_CFG 7'h68

// Field positions
`define HWM_BIT_HOT_EN1 6
`define HWM_BIT_INT_MODE 4
`define HWM_BIT_SENS_EN 1
`define HWM_BIT_PWM_DC 0
`define HWM_BIT_CLK_SEL 7
`define HWM_BIT_PWR_EN 0

// Reset values
`define HWM_RST_INDEX 7'h00
`define HWM_RST_BANK 3'h0
`define HWM_RST_FANFREQ 8'h04
`define HWM_RST_FANMODE 8'h00
`define HWM_RST_OVTCFG 8'h00
`define HWM_RST_PWR 8'h00

// Rates in kHz: core 125000, sources 24000 and 258
`define HWM_CLK_KHZ 17'h1e848
`define HWM_SRC0_KHZ 17'h05dc0
`define HWM_SRC1_KHZ 17'h00102

`endif

// *** shared/hwmon_pkg.sv ***
// Types shared by the monitor front end
package hwmon_pkg;
   typedef enum logic [1:0] {HWM_SEL_NONE, HWM_SEL_INDEX, HWM_SEL_DATA} hwmon_port_t;
   typedef logic [2:0] hwmon_bank_t;
   typedef logic [6:0] hwmon_index_t;
endpackage

// *** shared/hwmon_fan_if.sv ***
// Fan clock settings and period state between the register bank and the divider
`timescale 1ns/1ps
interface hwmon_fan_if;
   logic pwm_mode;
   logic clk_sel;
   logic [6:0] prescale;
   logic period_tick;
   logic [7:0] phase;
   modport ctrl(output pwm_mode, output clk_sel, output prescale,
      input period_tick, input phase);
   modport gen(input pwm_mode, input clk_sel, input prescale,
      output period_tick, output phase);
endinterface

// *** design/hwmon_fan_gen.sv ***
// Fan PWM clock source, mapped prescaler and 256-step period counter
`timescale 1ns/1ps
`include "hwmon_regs.svh"

module hwmon_fan_gen
   import hwmon_pkg::*;
#(
   parameter int DIV_W = 11
)(
   input wire logic clk_i,
   input wire logic rst_i,
   hwmon_fan_if.gen fan
);
   localparam int ACC_W = 17;

   logic [ACC_W-1:0] acc_reg, acc_next, inc;
   logic [ACC_W:0] acc_sum;
   logic src_tick, step;
   logic [DIV_W-1:0] div_reg, div_next, mapped;
   logic [7:0] phase_reg, phase_next;
   logic tick_reg, tick_next;

   function automatic logic [DIV_W-1:0] map_div(input logic sel, input logic [6:0] pre);
      logic [DIV_W-1:0] m;
      m = DIV_W'(4'h1);
      if (!sel) begin
         m = DIV_W'(pre) + DIV_W'(4'h1);
      end else if (!pre[3]) begin
         m = DIV_W'(pre[2:0]) + DIV_W'(4'h1);
      end else if (pre[3:0] == 4'h8) begin
         m = DIV_W'(4'hc);
      end else begin
         m = DIV_W'(4'h1) << (pre[3:0] - 4'h5);
      end
      return m;
   endfunction

   assign mapped = map_div(fan.clk_sel, fan.prescale);
   assign inc = fan.clk_sel ? `HWM_SRC1_KHZ : `HWM_SRC0_KHZ;

   always_comb begin
      acc_sum = {1'b0, acc_reg} + {1'b0, inc};
      acc_next = acc_sum[ACC_W-1:0];
      src_tick = 1'b0;
      step = 1'b0;
      div_next = div_reg;
      phase_next = phase_reg;
      tick_next = 1'b0;
      // Fractional accumulator keeps the long-run source rate exact
      if (acc_sum >= {1'b0, `HWM_CLK_KHZ}) begin
         acc_next = ACC_W'(acc_sum - {1'b0, `HWM_CLK_KHZ});
         src_tick = 1'b1;
      end
      if (src_tick) begin
         // Wrap on >= so a smaller divisor written mid-count takes hold at once
         if (div_reg >= mapped - DIV_W'(4'h1)) begin
            div_next = '0;
            step = 1'b1;
         end else begin
            div_next = div_reg + DIV_W'(4'h1);
         end
      end
      if (step) begin
         phase_next = phase_reg + 8'h01;
         tick_next = (phase_reg == 8'hff);
      end
      if (!fan.pwm_mode) begin
         acc_next = '0;
         div_next = '0;
         phase_next = 8'h00;
         tick_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_reg <= '0;
         div_reg <= '0;
         phase_reg <= 8'h00;
         tick_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         div_reg <= div_next;
         phase_reg <= phase_next;
         tick_reg <= tick_next;
      end
   end

   assign fan.period_tick = tick_reg;
   assign fan.phase = phase_reg;

   //---------------------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   fan_idle_hold_a: assert property (!fan.pwm_mode |=> phase_reg == 8'h00 && !tick_reg)
      else $error("fan counter runs while not in PWM mode");
   period_wrap_a: assert property (tick_reg
      |-> phase_reg == 8'h00 && $past(phase_reg) == 8'hff)
      else $error("period tick not at 256-step wrap");
   div_top_code_a: assert property (fan.clk_sel && fan.prescale[3:0] == 4'hf
      |-> mapped == DIV_W'(12'h400))
      else $error("slow source top code does not map to 1024");
   div_fast_map_a: assert property (!fan.clk_sel && fan.prescale == 7'h7f
      |-> mapped == DIV_W'(8'h80))
      else $error("fast source max field does not map to 128");
   // A switch to the fast source may tick at once, so only slow cycles count
   slow_src_gap_a: assert property (fan.clk_sel && src_tick
      |=> (!src_tick || !fan.clk_sel) [*8])
      else $error("slow source ticks too often");

   fan_period_c: cover property (tick_reg && fan.clk_sel);
endmodule // hwmon_fan_gen

// *** design/hwmon_top.sv ***
// Hardware monitor host port access, over-temperature alarm pin and fan clock setup
`timescale 1ns/1ps
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`include "hwmon_regs.svh"

module hwmon_top
   import hwmon_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [15:0] IO_ADDR_I,
   input wire logic IO_RD_I,
   input wire logic IO_WR_I,
   input wire logic [7:0] IO_WDATA_I,
   output logic [7:0] IO_RDATA_O,
   output logic IO_RVALID_O,
   input wire logic [7:0] BASE_HI_I,
   input wire logic [7:0] BASE_LO_I,
   input wire logic SMI_SEL_I,
   input wire logic MGMT_EVENT_I,
   input wire logic [5:0] TEMP_ABOVE_HIGH_I,
   input wire logic [5:0] TEMP_BELOW_HYST_I,
   input wire logic [7:0] POWER_CALC_I,
   input wire logic ALARM_PIN_I,
   output logic ALARM_PIN_O,
   output logic ALARM_PIN_OE_O,
   output logic FAN_PWM_TICK_O,
   output logic [7:0] FAN_PWM_PHASE_O
);
   localparam int NUM_SENS = 6;

   //---------------------------------------------------------------------------
   // Port decode
   //---------------------------------------------------------------------------
   logic [15:0] base_addr;
   hwmon_port_t port_sel;
   hwmon_bank_t eff_bank;
   logic wr_data, rd_data, rd_stat_a, rd_stat_b;

   hwmon_index_t index_reg, index_next;
   hwmon_bank_t bank_reg, bank_next;
   logic [7:0] fanfreq_reg, fanfreq_next;
   logic [7:0] fanmode_reg, fanmode_next;
   logic [7:0] ovtcfg_reg, ovtcfg_next;
   logic [4:0] sens_reg, sens_next;
   logic [7:0] pwr_val_reg, pwr_val_next;
   logic pwr_cfg_reg, pwr_cfg_next;
   logic [7:0] rdata_reg, rdata_next, rd_mux;
   logic rvalid_reg, rvalid_next;

   logic [NUM_SENS-1:0] en_vec, hot_reg, hot_next, evt;
   logic [NUM_SENS-1:0] pend_reg, pend_next;
   logic [1:0] stat_rd_reg, stat_rd_next;
   logic clr_all, int_mode, cmp_alarm;
   logic alarm_reg, alarm_next;
   logic pin_meta_reg, pin_sync_reg;

   assign base_addr = {BASE_HI_I, BASE_LO_I};

   always_comb begin
      if (IO_ADDR_I == base_addr + `HWM_PORT_INDEX) begin
         port_sel = HWM_SEL_INDEX;
      end else if (IO_ADDR_I == base_addr + `HWM_PORT_DATA) begin
         port_sel = HWM_SEL_DATA;
      end else begin
         port_sel = HWM_SEL_NONE;
      end
   end

   // Bank select must stay reachable, or a wrong bank would lock software out
   assign eff_bank = (index_reg == `HWM_IDX_BANKSEL) ? `HWM_BANK0 : bank_reg;

   function automatic logic at(input hwmon_bank_t b, input hwmon_index_t i);
      return (eff_bank == b) && (index_reg == i);
   endfunction

   assign wr_data = IO_WR_I && (port_sel == HWM_SEL_DATA);
   assign rd_data = IO_RD_I && (port_sel == HWM_SEL_DATA);
   // Spelled out: a continuous assign would miss the function's hidden reads
   assign rd_stat_a = rd_data && eff_bank == `HWM_BANK0 && index_reg == `HWM_IDX_STAT_A;
   assign rd_stat_b = rd_data && eff_bank == `HWM_BANK0 && index_reg == `HWM_IDX_STAT_B;

   //---------------------------------------------------------------------------
   // Read multiplexer
   //---------------------------------------------------------------------------
   always_comb begin
      rd_mux = 8'h00;
      if (at(`HWM_BANK0, `HWM_IDX_FANFREQ)) begin
         rd_mux = fanfreq_reg;
      end else if (at(`HWM_BANK0, `HWM_IDX_FANMODE)) begin
         rd_mux = fanmode_reg;
      end else if (at(`HWM_BANK0, `HWM_IDX_OVTCFG)) begin
         rd_mux = ovtcfg_reg;
      end else if (at(`HWM_BANK0, `HWM_IDX_BANKSEL)) begin
         rd_mux = {5'h00, bank_reg};
      end else if (at(`HWM_BANK0, `HWM_IDX_STAT_A)) begin
         rd_mux = {5'h00, pend_reg[2:0]};
      end else if (at(`HWM_BANK0, `HWM_IDX_STAT_B)) begin
         rd_mux = {pin_sync_reg, 4'h0, pend_reg[5:3]};
      end else if (at(`HWM_BANK1, `HWM_IDX_SENS_EN)) begin
         rd_mux = {6'h00, sens_reg[0], 1'b0};
      end else if (at(`HWM_BANK2, `HWM_IDX_SENS_EN)) begin
         rd_mux = {6'h00, sens_reg[1], 1'b0};
      end else if (at(`HWM_BANK6, `HWM_IDX_SENS4)) begin
         rd_mux = {6'h00, sens_reg[2], 1'b0};
      end else if (at(`HWM_BANK6, `HWM_IDX_SENS5)) begin
         rd_mux = {6'h00, sens_reg[3], 1'b0};
      end else if (at(`HWM_BANK6, `HWM_IDX_SENS6)) begin
         rd_mux = {6'h00, sens_reg[4], 1'b0};
      end else if (at(`HWM_BANK4, `HWM_IDX_PWR_VAL)) begin
         rd_mux = pwr_cfg_reg ? POWER_CALC_I : pwr_val_reg;
      end else if (at(`HWM_BANK4, `HWM_IDX_PWR_CFG)) begin
         rd_mux = {7'h00, pwr_cfg_reg};
      end
   end

   //---------------------------------------------------------------------------
   // Host register group
   //---------------------------------------------------------------------------
   always_comb begin
      index_next = index_reg;
      bank_next = bank_reg;
      fanfreq_next = fanfreq_reg;
      fanmode_next = fanmode_reg;
      ovtcfg_next = ovtcfg_reg;
      sens_next = sens_reg;
      pwr_val_next = pwr_val_reg;
      pwr_cfg_next = pwr_cfg_reg;
      rdata_next = rdata_reg;
      rvalid_next = 1'b0;
      if (IO_WR_I && port_sel == HWM_SEL_INDEX) begin
         index_next = IO_WDATA_I[6:0];
      end
      if (wr_data) begin
         if (at(`HWM_BANK0, `HWM_IDX_BANKSEL)) begin
            bank_next = IO_WDATA_I[2:0];
         end
         if (at(`HWM_BANK0, `HWM_IDX_FANFREQ)) begin
            fanfreq_next = IO_WDATA_I;
         end
         if (at(`HWM_BANK0, `HWM_IDX_FANMODE)) begin
            fanmode_next = IO_WDATA_I;
         end
         if (at(`HWM_BANK0, `HWM_IDX_OVTCFG)) begin
            ovtcfg_next = IO_WDATA_I;
         end
         if (at(`HWM_BANK1, `HWM_IDX_SENS_EN)) begin
            sens_next[0] = IO_WDATA_I[`HWM_BIT_SENS_EN];
         end
         if (at(`HWM_BANK2, `HWM_IDX_SENS_EN)) begin
            sens_next[1] = IO_WDATA_I[`HWM_BIT_SENS_EN];
         end
         if (at(`HWM_BANK6, `HWM_IDX_SENS4)) begin
            sens_next[2] = IO_WDATA_I[`HWM_BIT_SENS_EN];
         end
         if (at(`HWM_BANK6, `HWM_IDX_SENS5)) begin
            sens_next[3] = IO_WDATA_I[`HWM_BIT_SENS_EN];
         end
         if (at(`HWM_BANK6, `HWM_IDX_SENS6)) begin
            sens_next[4] = IO_WDATA_I[`HWM_BIT_SENS_EN];
         end
         if (at(`HWM_BANK4, `HWM_IDX_PWR_VAL)) begin
            pwr_val_next = IO_WDATA_I;
         end
         if (at(`HWM_BANK4, `HWM_IDX_PWR_CFG)) begin
            pwr_cfg_next = IO_WDATA_I[`HWM_BIT_PWR_EN];
         end
      end
      if (IO_RD_I && port_sel != HWM_SEL_NONE) begin
         rvalid_next = 1'b1;
         if (port_sel == HWM_SEL_INDEX) begin
            rdata_next = {1'b0, index_reg};
         end else begin
            rdata_next = rd_mux;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         index_reg <= `HWM_RST_INDEX;
         bank_reg <= `HWM_RST_BANK;
         fanfreq_reg <= `HWM_RST_FANFREQ;
         fanmode_reg <= `HWM_RST_FANMODE;
         ovtcfg_reg <= `HWM_RST_OVTCFG;
         sens_reg <= 5'h00;
         pwr_val_reg <= `HWM_RST_PWR;
         pwr_cfg_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         index_reg <= index_next;
         bank_reg <= bank_next;
         fanfreq_reg <= fanfreq_next;
         fanmode_reg <= fanmode_next;
         ovtcfg_reg <= ovtcfg_next;
         sens_reg <= sens_next;
         pwr_val_reg <= pwr_val_next;
         pwr_cfg_reg <= pwr_cfg_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign IO_RDATA_O = rdata_reg;
   assign IO_RVALID_O = rvalid_reg;

   //---------------------------------------------------------------------------
   // Over-temperature alarm
   //---------------------------------------------------------------------------
   assign en_vec = {sens_reg, ovtcfg_reg[`HWM_BIT_HOT_EN1]};
   assign int_mode = ovtcfg_reg[`HWM_BIT_INT_MODE];

   // Above-high wins if both comparator flags are seen together
   for (genvar g = 0; g < NUM_SENS; g++) begin : g_sens
      assign hot_next[g] = TEMP_ABOVE_HIGH_I[g] | (hot_reg[g] & ~TEMP_BELOW_HYST_I[g]);
      assign evt[g] = hot_next[g] ^ hot_reg[g];
   end

   always_comb begin
      stat_rd_next = stat_rd_reg | {rd_stat_b, rd_stat_a};
      clr_all = &stat_rd_next;
      if (clr_all) begin
         stat_rd_next = 2'b00;
      end
      // A new event in the clearing cycle survives the clear
      pend_next = pend_reg & ~{NUM_SENS{clr_all}};
      if (int_mode) begin
         pend_next = pend_next | (evt & en_vec);
      end
      cmp_alarm = |(hot_next & en_vec);
      if (SMI_SEL_I) begin
         alarm_next = MGMT_EVENT_I;
      end else if (int_mode) begin
         alarm_next = |pend_next;
      end else begin
         alarm_next = cmp_alarm;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         hot_reg <= '0;
         pend_reg <= '0;
         stat_rd_reg <= 2'b00;
         alarm_reg <= 1'b0;
      end else begin
         hot_reg <= hot_next;
         pend_reg <= pend_next;
         stat_rd_reg <= stat_rd_next;
         alarm_reg <= alarm_next;
      end
   end

   // Open drain, active low: only ever pull the wire down
   assign ALARM_PIN_O = 1'b0;
   assign ALARM_PIN_OE_O = alarm_reg;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= ALARM_PIN_I;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   //---------------------------------------------------------------------------
   // Fan clock divider
   //---------------------------------------------------------------------------
   hwmon_fan_if fan_bus();

   assign fan_bus.pwm_mode = ~fanmode_reg[`HWM_BIT_PWM_DC];
   assign fan_bus.clk_sel = fanfreq_reg[`HWM_BIT_CLK_SEL];
   assign fan_bus.prescale = fanfreq_reg[6:0];

   hwmon_fan_gen u_fan (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .fan(fan_bus.gen)
   );

   assign FAN_PWM_TICK_O = fan_bus.period_tick;
   assign FAN_PWM_PHASE_O = fan_bus.phase;

   //---------------------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   logic pwr_read;
   assign pwr_read = rd_data && eff_bank == `HWM_BANK4 && index_reg == `HWM_IDX_PWR_VAL;

   index_write_a: assert property (IO_WR_I && port_sel == HWM_SEL_INDEX
      |=> index_reg == $past(IO_WDATA_I[6:0]))
      else $error("index pointer did not take written value");
   index_read_a: assert property (IO_RD_I && port_sel == HWM_SEL_INDEX
      |=> IO_RVALID_O && IO_RDATA_O == {1'b0, $past(index_reg)})
      else $error("index port read wrong or bit 7 set");
   bank_any_a: assert property (wr_data && index_reg == `HWM_IDX_BANKSEL
      |=> bank_reg == $past(IO_WDATA_I[2:0]))
      else $error("bank select not written from current bank");
   fan_write_a: assert property (wr_data && at(`HWM_BANK0, `HWM_IDX_FANFREQ)
      |=> fanfreq_reg == $past(IO_WDATA_I))
      else $error("fan frequency register not updated");
   pwr_select_a: assert property (pwr_read
      |=> IO_RDATA_O == ($past(pwr_cfg_reg) ? $past(POWER_CALC_I) : $past(pwr_val_reg)))
      else $error("power value source wrong");
   smi_route_a: assert property (SMI_SEL_I |=> ALARM_PIN_OE_O == $past(MGMT_EVENT_I))
      else $error("pin not following management interrupt");
   cmp_alarm_a: assert property (!SMI_SEL_I && !int_mode
      |=> ALARM_PIN_OE_O == $past(cmp_alarm))
      else $error("comparator alarm level wrong");
   hot_hold_a: assert property (hot_reg[0] && !TEMP_BELOW_HYST_I[0]
      |-> !evt[0] ##1 hot_reg[0])
      else $error("sensor left high state above hysteresis");
   pend_keep_a: assert property (!clr_all |=> (pend_reg & $past(pend_reg)) == $past(pend_reg))
      else $error("pending event dropped without full status read");
   int_hold_a: assert property (!SMI_SEL_I && int_mode && pend_reg != 6'h00 && !clr_all
      |=> ALARM_PIN_OE_O)
      else $error("alarm released while event pending");
   mask_off_a: assert property (!SMI_SEL_I && !int_mode && (hot_next & en_vec) == 6'h00
      |=> !ALARM_PIN_OE_O)
      else $error("disabled sensor drives the alarm pin");

   int_event_c: cover property (int_mode && pend_reg != 6'h00 ##[1:50] clr_all);
   bank_switch_c: cover property (wr_data && index_reg == `HWM_IDX_BANKSEL && bank_reg != 3'h0);
   smi_pin_c: cover property (SMI_SEL_I && ALARM_PIN_OE_O);
   cmp_alarm_c: cover property (!int_mode && ALARM_PIN_OE_O ##1 !ALARM_PIN_OE_O);
endmodule // hwmon_top

// *** sim/hwmon_host.sv ***
// Host CPU model issuing I/O port accesses to the monitor
`timescale 1ns/1ps
module hwmon_host #(
   parameter logic [15:0] BASE = 16'h0290
)(
   input wire logic clk_i,
   output logic [15:0] addr_o,
   output logic rd_o,
   output logic wr_o,
   output logic [7:0] wdata_o
);
   initial begin
      {addr_o, rd_o, wr_o, wdata_o} = '0;
   end
   // One-cycle strobe; released lines show inverted values, not the old ones
   task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      rd_o <= ~w;
      wr_o <= w;
      @(posedge clk_i);
      {rd_o, wr_o} <= 2'b00;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   task automatic xs(input logic [2:0] b, input logic [6:0] i, input logic w,
         input logic [7:0] d);
      if (i != 7'h4e) begin
         acc(BASE + 16'h5, 1'b1, 8'h4e);
         acc(BASE + 16'h6, 1'b1, {5'h00, b});
      end
      acc(BASE + 16'h5, 1'b1, {1'b0, i});
      acc(BASE + 16'h6, w, d);
   endtask
endmodule // hwmon_host

// *** sim/hwmon_top_bench.sv ***
// Self-checking bench of the monitor front end
`timescale 1ns/1ps
module hwmon_top_bench;
   import hwmon_pkg::*;
   localparam logic [15:0] BASE = 16'h0290;
   logic clk, rst, smi_sel, mgmt, pin_in, dout, oe, rvalid, rd, wr, tick;
   logic [15:0] addr;
   logic [7:0] wdata, rdata, pcalc, phase, v;
   logic [5:0] hot, cool;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h283c;
   int bad_count = 0;
   int n_tests = 0;
   assign pin_in = oe ? 1'b0 : 1'b1;
   hwmon_top i_dut (.CLK_I(clk), .RST_I(rst), .IO_ADDR_I(addr), .IO_RD_I(rd),
      .IO_WR_I(wr), .IO_WDATA_I(wdata), .IO_RDATA_O(rdata), .IO_RVALID_O(rvalid),
      .BASE_HI_I(BASE[15:8]), .BASE_LO_I(BASE[7:0]), .SMI_SEL_I(smi_sel),
      .MGMT_EVENT_I(mgmt), .TEMP_ABOVE_HIGH_I(hot), .TEMP_BELOW_HYST_I(cool),
      .POWER_CALC_I(pcalc), .ALARM_PIN_I(pin_in), .ALARM_PIN_O(dout),
      .ALARM_PIN_OE_O(oe), .FAN_PWM_TICK_O(tick), .FAN_PWM_PHASE_O(phase));
   hwmon_host #(.BASE(BASE)) i_host (.clk_i(clk), .addr_o(addr), .rd_o(rd),
      .wr_o(wr), .wdata_o(wdata));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic rdx(input logic [2:0] b, input logic [6:0] i, input logic [7:0] e);
      exp_q.push_back(e);
      i_host.xs(b, i, 1'b0, 8'h00);
   endtask
   task automatic pulse(input logic [5:0] h, input logic [5:0] c, input logic e);
      @(posedge clk);
      {hot, cool} <= {h, c};
      @(posedge clk);
      {hot, cool} <= '0;
      repeat (3) @(negedge clk);
      chk("alarm oe", e, oe);
   endtask
   // Tolerates one cycle of jitter from the fractional source accumulator
   task automatic meas(input bit tk, input int m, input int src);
      int n;
      int e;
      logic [7:0] p;
      n = 0;
      e = 125000 * m * (tk ? 256 : 1) / src;
      @(negedge clk);
      p = phase;
      while (tk ? tick !== 1'b1 : phase === p) @(negedge clk);
      p = phase;
      do begin
         n++;
         @(negedge clk);
      end while (tk ? tick !== 1'b1 : phase === p);
      if (n == e + 1 || n == e - 1) n = e;
      chk("fan interval", e[15:0], n[15:0]);
   endtask
   // ---------------------------------------------------------------
   // Read answers checked in order of request
   // ---------------------------------------------------------------
   always @(negedge clk) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) chk("stray answer", 16'h0, 16'h1);
         else chk("read data", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
      end
   end
   initial begin
      #(8 * 60000);
      bad_count++;
      complete_run();
   end
   initial begin
      {rst, smi_sel, mgmt, hot, cool} = {3'b100, 12'h000};
      seed = lfsr(seed);
      pcalc = seed[7:0];
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      exp_q.push_back(8'h00);
      i_host.acc(BASE + 16'h5, 1'b0, 8'h00);
      i_host.acc(BASE + 16'h5, 1'b1, 8'hff);
      exp_q.push_back(8'h7f);
      i_host.acc(BASE + 16'h5, 1'b0, 8'h00);
      rdx(3'h0, 7'h00, 8'h04);
      seed = lfsr(seed);
      v = {seed[15], seed[6:0] % 7'h7f + 7'h01};
      i_host.xs(3'h0, 7'h00, 1'b1, v);
      rdx(3'h0, 7'h00, v);
      i_host.acc(BASE + 16'h7, 1'b0, 8'h00);
      i_host.acc(BASE + 16'h4, 1'b1, 8'h55);
      i_host.xs(3'h1, 7'h52, 1'b1, 8'h02);
      i_host.acc(BASE + 16'h5, 1'b1, 8'h4e);
      exp_q.push_back(8'h01);
      i_host.acc(BASE + 16'h6, 1'b0, 8'h00);
      rdx(3'h1, 7'h52, 8'h02);
      rdx(3'h2, 7'h52, 8'h00);
      pulse(6'h01, 6'h00, 1'b0);
      pulse(6'h02, 6'h00, 1'b1);
      pulse(6'h00, 6'h03, 1'b0);
      i_host.xs(3'h0, 7'h18, 1'b1, 8'h50);
      pulse(6'h01, 6'h00, 1'b1);
      rdx(3'h0, 7'h41, 8'h01);
      repeat (3) @(negedge clk);
      chk("alarm oe", 1'b1, oe);
      rdx(3'h0, 7'h42, 8'h00);
      repeat (3) @(negedge clk);
      chk("alarm oe", 1'b0, oe);
      pulse(6'h01, 6'h00, 1'b0);
      pulse(6'h00, 6'h01, 1'b1);
      rdx(3'h0, 7'h42, 8'h00);
      rdx(3'h0, 7'h41, 8'h01);
      repeat (3) @(negedge clk);
      chk("alarm oe", 1'b0, oe);
      @(posedge clk);
      smi_sel <= 1'b1;
      mgmt <= 1'b1;
      repeat (3) @(negedge clk);
      chk("mgmt oe", 1'b1, oe);
      @(posedge clk);
      mgmt <= 1'b0;
      repeat (3) @(negedge clk);
      chk("mgmt oe", 1'b0, oe);
      @(posedge clk);
      smi_sel <= 1'b0;
      chk("pin drive", 1'b0, dout);
      i_host.xs(3'h4, 7'h67, 1'b1, 8'h5a);
      rdx(3'h4, 7'h67, 8'h5a);
      i_host.xs(3'h4, 7'h68, 1'b1, 8'h01);
      rdx(3'h4, 7'h67, pcalc);
      i_host.xs(3'h0, 7'h00, 1'b1, 8'h03);
      meas(1'b0, 4, 24000);
      i_host.xs(3'h0, 7'h00, 1'b1, 8'h01);
      meas(1'b1, 2, 24000);
      i_host.xs(3'h0, 7'h00, 1'b1, 8'h81);
      meas(1'b0, 2, 258);
      i_host.xs(3'h0, 7'h00, 1'b1, 8'h88);
      meas(1'b0, 12, 258);
      i_host.xs(3'h0, 7'h00, 1'b1, 8'h8f);
      rdx(3'h0, 7'h00, 8'h8f);
      i_host.xs(3'h0, 7'h00, 1'b1, 8'h7f);
      rdx(3'h0, 7'h00, 8'h7f);
      i_host.xs(3'h0, 7'h04, 1'b1, 8'h01);
      repeat (4) @(negedge clk);
      repeat (600) @(negedge clk) chk("dc mode fan", 16'h0, {7'h00, tick, phase});
      chk("pending reads", 16'h0, 16'(exp_q.size()));
      complete_run();
   end
endmodule // hwmon_top_bench
